// ### design/nv_map.svh
`ifndef NV_MAP_SVH
`define NV_MAP_SVH
// Register byte offsets
`define NV_OFF_DATA 4'h0
`define NV_OFF_CTL 4'h4
`define NV_OFF_ADDR 4'h8
`define NV_OFF_STAT 4'hC
// Control register bit positions
`define NV_CTL_RDS 0
`define NV_CTL_PRS 1
`define NV_CTL_MPE 2
`define NV_CTL_RIE 3
`define NV_CTL_PM_LO 4
`define NV_CTL_PM_HI 5
// Reset values
`define NV_DATA_RST 8'h00
`define NV_ADDR_RST 12'h000
`define NV_MODE_RST 2'h0
// Bus responses
`define NV_RESP_OKAY 2'h0
`define NV_RESP_SLVERR 2'h2
// Timing in aclk cycles
`define NV_MPE_CYC 3'h4
`define NV_RD_STALL 3'h4
`define NV_PR_STALL 3'h2
// Programming times, ns, and RC cycles for the atomic case
`define NV_T_ATOMIC_NS 64'd3400000
`define NV_T_SPLIT_NS 64'd1800000
`define NV_RC_ATOMIC 64'd26368
`endif

// ### design/nv_pkg.sv
package nv_pkg;
    // Controller state, one-hot
    typedef enum logic [1:0] {
        NV_IDLE = 2'b01,
        NV_PROG = 2'b10
    } nv_state_e;
    // Programming mode field codes
    typedef enum logic [1:0] {
        NV_PM_ATOMIC = 2'b00,
        NV_PM_ERASE = 2'b01,
        NV_PM_WRITE = 2'b10,
        NV_PM_RSVD = 2'b11
    } nv_mode_e;
    // Request to the memory array
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic erase;
        logic write;
    } nv_mem_req_s;
endpackage

// ### design/nv_tick_sync.sv
`timescale 1ns/1ps
module nv_tick_sync (
    // Clock, enable and reset
    input wire logic aclk,
    input wire logic resetn,
    input wire logic aclk_en,
    // Asynchronous input and its rising-edge pulse
    input wire logic async_in,
    output logic tick
);
    logic meta;
    logic sync;
    logic sync_d;

    // Two-stage synchroniser plus edge history
    always_ff @(posedge aclk) begin
        if (!resetn) begin
            meta <= 1'b0;
            sync <= 1'b0;
            sync_d <= 1'b0;
        end else if (aclk_en) begin
            meta <= async_in;
            sync <= meta;
            sync_d <= sync;
        end
    end

    // One pulse per rising edge
    assign tick = aclk_en & sync & ~sync_d;
endmodule // nv_tick_sync

// ### design/nv_ctrl.sv
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "nv_map.svh"
module nv_ctrl #(
    parameter int unsigned TMR_W = 15,
    parameter int unsigned ATOMIC_RC_CYC = int'(`NV_RC_ATOMIC),
    parameter int unsigned SPLIT_RC_CYC = int'((`NV_RC_ATOMIC * `NV_T_SPLIT_NS
        + `NV_T_ATOMIC_NS - 64'd1) / `NV_T_ATOMIC_NS)
) (
    // Clock, enable, resets
    input wire logic aclk,
    input wire logic aclk_en,
    input wire logic aresetn,
    input wire logic por_resetn,
    // AXI4-Lite write channels
    input wire logic [3:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [3:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Chip side
    input wire logic cpu_status_word_gie,
    input wire logic flash_selfprog_active,
    input wire logic rc_osc_clk,
    output logic cpu_stall,
    output logic ready_irq,
    // Memory array
    output nv_pkg::nv_mem_req_s mem_req,
    input wire logic [7:0] mem_rdata
);
    import nv_pkg::*;

    logic aw_ful;
    logic w_ful;
    logic [3:0] aw_a;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic wr_go;
    logic wr_ctl;
    logic [7:0] nv_data_byte;
    logic [11:0] nv_byte_address;
    logic [7:0] prog_wdata;
    logic [1:0] prog_mode_field;
    logic ready_irq_enable;
    logic master_prog_enable;
    logic [2:0] mpe_cnt;
    logic prog_strobe;
    nv_state_e state;
    logic [TMR_W-1:0] tmr;
    logic [2:0] stall_cnt;
    logic rc_tick;
    logic start;
    logic rd_go;
    logic [1:0] next_mode;
    logic map_ok;

    // RC oscillator edges into the aclk domain
    nv_tick_sync u_rc_sync (
        .aclk(aclk),
        .resetn(por_resetn),
        .aclk_en(aclk_en),
        .async_in(rc_osc_clk),
        .tick(rc_tick)
    );

    // Write channel handshakes
    assign awready = ~aw_ful & ~bvalid;
    assign wready = ~w_ful & ~bvalid;
    assign wr_go = aw_ful & w_ful & ~bvalid;
    assign wr_ctl = wr_go & (aw_a == `NV_OFF_CTL) & w_s[0];
    assign next_mode = w_d[`NV_CTL_PM_HI:`NV_CTL_PM_LO];
    assign map_ok = (aw_a == `NV_OFF_DATA) | (aw_a == `NV_OFF_CTL)
        | (aw_a == `NV_OFF_ADDR) | (aw_a == `NV_OFF_STAT);

    // Address and data taken in either order, then one response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ful <= 1'b0;
            w_ful <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `NV_RESP_OKAY;
            aw_a <= 4'h0;
            w_d <= 32'h0;
            w_s <= 4'h0;
        end else if (aclk_en) begin
            if (awvalid && awready) begin
                aw_ful <= 1'b1;
                aw_a <= awaddr;
            end
            if (wvalid && wready) begin
                w_ful <= 1'b1;
                w_d <= wdata;
                w_s <= wstrb;
            end
            if (wr_go) begin
                aw_ful <= 1'b0;
                w_ful <= 1'b0;
                bvalid <= 1'b1;
                bresp <= map_ok ? `NV_RESP_OKAY : `NV_RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Read channel, one cycle after the address
    assign arready = ~rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= `NV_RESP_OKAY;
        end else if (aclk_en) begin
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp <= `NV_RESP_OKAY;
                case (araddr)
                    `NV_OFF_DATA: rdata <= {24'h0, nv_data_byte};
                    `NV_OFF_CTL: rdata <= {24'h0, 2'b00, prog_mode_field, ready_irq_enable,
                        master_prog_enable, prog_strobe, 1'b0};
                    `NV_OFF_ADDR: rdata <= {20'h0, nv_byte_address};
                    `NV_OFF_STAT: rdata <= {30'h0, ready_irq, cpu_stall};
                    default: begin
                        rdata <= 32'h0;
                        rresp <= `NV_RESP_SLVERR;
                    end
                endcase
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // start only inside the enable window, never during flash
    assign start = wr_ctl & w_d[`NV_CTL_PRS] & master_prog_enable & ~prog_strobe
        & ~flash_selfprog_active & (next_mode != NV_PM_RSVD);
    assign rd_go = wr_ctl & w_d[`NV_CTL_RDS] & ~prog_strobe;
    assign prog_strobe = (state == NV_PROG);

    // Master enable and its four-cycle expiry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            master_prog_enable <= 1'b0;
            mpe_cnt <= 3'h0;
        end else if (aclk_en) begin
            if (wr_ctl && w_d[`NV_CTL_MPE] && !master_prog_enable) begin
                master_prog_enable <= 1'b1;
                mpe_cnt <= `NV_MPE_CYC;
            end else if (master_prog_enable) begin
                mpe_cnt <= mpe_cnt - 3'h1;
                if (mpe_cnt == 3'h1) begin
                    master_prog_enable <= 1'b0;
                end
            end
        end
    end

    // mode survives an aresetn reset during programming, por_resetn still clears it
    always_ff @(posedge aclk) begin
        if (!por_resetn || (!aresetn && !prog_strobe)) begin
            prog_mode_field <= `NV_MODE_RST;
        end else if (aclk_en && wr_ctl && !prog_strobe) begin
            prog_mode_field <= next_mode;
        end
    end

    // Ready interrupt enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ready_irq_enable <= 1'b0;
        end else if (aclk_en && wr_ctl) begin
            ready_irq_enable <= w_d[`NV_CTL_RIE];
        end
    end

    always_ff @(posedge aclk) begin
        if (!por_resetn) begin
            state <= NV_IDLE;
        end else if (aclk_en) begin
            case (state)
                NV_IDLE: begin
                    if (start) begin
                        state <= NV_PROG;
                    end
                end
                NV_PROG: begin
                    if (rc_tick && tmr == TMR_W'(1)) begin
                        state <= NV_IDLE;
                    end
                end
                default: state <= NV_IDLE;
            endcase
        end
    end

    // RC cycle timer, length by mode
    always_ff @(posedge aclk) begin
        if (!por_resetn) begin
            tmr <= '0;
        end else if (aclk_en) begin
            if (start) begin
                tmr <= (next_mode == NV_PM_ATOMIC) ? TMR_W'(ATOMIC_RC_CYC)
                    : TMR_W'(SPLIT_RC_CYC);
            end else if (prog_strobe && rc_tick) begin
                tmr <= tmr - TMR_W'(1);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!por_resetn) begin
            prog_wdata <= `NV_DATA_RST;
        end else if (aclk_en && start) begin
            prog_wdata <= nv_data_byte;
        end
    end

    // Data register, software or array read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nv_data_byte <= `NV_DATA_RST;
        end else if (aclk_en) begin
            if (rd_go) begin
                nv_data_byte <= mem_rdata;
            end else if (wr_go && aw_a == `NV_OFF_DATA && w_s[0]) begin
                nv_data_byte <= w_d[7:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!por_resetn) begin
            nv_byte_address <= `NV_ADDR_RST;
        end else if (aclk_en && wr_go && aw_a == `NV_OFF_ADDR && !prog_strobe) begin
            if (w_s[0]) begin
                nv_byte_address[7:0] <= w_d[7:0];
            end
            if (w_s[1]) begin
                nv_byte_address[11:8] <= w_d[11:8];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stall_cnt <= 3'h0;
        end else if (aclk_en) begin
            if (rd_go) begin
                stall_cnt <= `NV_RD_STALL;
            end else if (start) begin
                stall_cnt <= `NV_PR_STALL;
            end else if (stall_cnt != 3'h0) begin
                stall_cnt <= stall_cnt - 3'h1;
            end
        end
    end
    assign cpu_stall = (stall_cnt != 3'h0);

    assign ready_irq = ready_irq_enable & cpu_status_word_gie & ~prog_strobe;

    // Array request from held state
    assign mem_req.addr = nv_byte_address;
    assign mem_req.wdata = prog_wdata;
    assign mem_req.erase = prog_strobe & (prog_mode_field != NV_PM_WRITE);
    assign mem_req.write = prog_strobe & (prog_mode_field != NV_PM_ERASE);

    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn || !aclk_en || !por_resetn);

    sequence s_rd_stall;
        cpu_stall [*4];
    endsequence
    sequence s_pr_stall;
        cpu_stall [*2] ##1 !cpu_stall;
    endsequence

    chk_rsvd_ctl_zero: assert property (
        (arvalid && arready && araddr == `NV_OFF_CTL) |=> rdata[7:6] == 2'b00)
        else $error("reserved control bits not zero");
    chk_mpe_expiry: assert property (
        $rose(master_prog_enable) |-> master_prog_enable [*4] ##1 !master_prog_enable)
        else $error("master enable did not expire after four cycles");
    chk_start_gated: assert property (
        start |-> master_prog_enable && $past(master_prog_enable, 4) == 1'b0 ||
        master_prog_enable && mpe_cnt != 3'h0)
        else $error("programming started without master enable");
    chk_no_flash_clash: assert property (
        $rose(prog_strobe) |-> $past(!flash_selfprog_active))
        else $error("programming started during flash self-programming");
    chk_mode_frozen: assert property (
        prog_strobe |=> $stable(prog_mode_field))
        else $error("mode changed while strobe set");
    chk_ready_irq_on: assert property (
        (ready_irq_enable && cpu_status_word_gie && $fell(prog_strobe)) |-> ready_irq)
        else $error("ready interrupt missing after completion");
    chk_read_stall: assert property (
        rd_go |=> s_rd_stall and (nv_data_byte == $past(mem_rdata)))
        else $error("read stall or data wrong");
    chk_prog_stall: assert property (
        start |=> s_pr_stall)
        else $error("programming stall not two cycles");
    chk_busy_lock: assert property (
        prog_strobe |=> $stable(nv_byte_address) && !$past(rd_go))
        else $error("address or read accepted while busy");
    chk_prog_load: assert property (
        start |=> tmr == (($past(next_mode) == NV_PM_ATOMIC) ? TMR_W'(ATOMIC_RC_CYC)
            : TMR_W'(SPLIT_RC_CYC)) && prog_strobe)
        else $error("timer not loaded with programming time");
    chk_data_latched: assert property (
        start |=> mem_req.wdata == $past(nv_data_byte) && mem_req.write ==
            (prog_mode_field != NV_PM_ERASE))
        else $error("programmed byte not captured");
    chk_strobe_end: assert property (
        (prog_strobe && rc_tick && tmr == TMR_W'(1)) |=> !prog_strobe)
        else $error("strobe not cleared at completion");
    chk_reset_mode: assert property (
        @(posedge aclk) disable iff (!por_resetn)
        (!aresetn && !prog_strobe) |=> prog_mode_field == `NV_MODE_RST)
        else $error("mode not cleared by reset");
endmodule // nv_ctrl

// ### tb/nv_mem_model.sv
`timescale 1ns/1ps
module nv_mem_model (
    // Clock
    input wire logic aclk,
    // Request from the controller and read data back
    input wire nv_pkg::nv_mem_req_s mem_req,
    output logic [7:0] mem_rdata
);
    import nv_pkg::*;
    logic [7:0] mem [0:4095];
    logic busy_q;
    nv_mem_req_s req_q;

    // Known pattern so reads before any write are predictable
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = i[7:0] ^ 8'h5A;
        end
    end

    assign mem_rdata = mem[mem_req.addr];

    always @(posedge aclk) begin
        busy_q <= mem_req.erase | mem_req.write;
        req_q <= mem_req;
        if (busy_q && !(mem_req.erase || mem_req.write)) begin
            if (req_q.erase && req_q.write) begin
                mem[req_q.addr] <= req_q.wdata;
            end else if (req_q.erase) begin
                mem[req_q.addr] <= 8'hFF;
            end else begin
                mem[req_q.addr] <= mem[req_q.addr] & req_q.wdata;
            end
        end
    end
endmodule // nv_mem_model

// ### tb/tb_top.sv
`timescale 1ns/1ps
`include "nv_map.svh"
module tb_top;
    import nv_pkg::*;
    logic aclk, aclk_en, aresetn, por_resetn, rc_osc_clk, gie, flash_busy;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, rv;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, rr, wb;
    logic cpu_stall, ready_irq;
    nv_mem_req_s mem_req;
    logic [7:0] mem_rdata;
    int mismatches, checks_done, stall_run, last_stall, busy_run, last_busy;
    logic [1:0] modes [3];
    logic [7:0] exps [3];

    nv_ctrl #(.ATOMIC_RC_CYC(20), .SPLIT_RC_CYC(10)) nv_ctrl_inst (
        .aclk(aclk), .aclk_en(aclk_en), .aresetn(aresetn), .por_resetn(por_resetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .cpu_status_word_gie(gie), .flash_selfprog_active(flash_busy),
        .rc_osc_clk(rc_osc_clk), .cpu_stall(cpu_stall), .ready_irq(ready_irq),
        .mem_req(mem_req), .mem_rdata(mem_rdata)
    );

    nv_mem_model nv_mem_model_inst (.aclk(aclk), .mem_req(mem_req), .mem_rdata(mem_rdata));

    // System clock and free-running oscillator
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial begin
        rc_osc_clk = 1'b0;
        forever #170 rc_osc_clk = ~rc_osc_clk; // Slower than aclk/2, no lost edges
    end

    // Length of the last stall pulse and of the last array busy period
    always @(posedge aclk) begin
        if (cpu_stall === 1'b1) begin
            stall_run <= stall_run + 1;
        end else if (stall_run != 0) begin
            last_stall <= stall_run;
            stall_run <= 0;
        end
        if ((mem_req.erase | mem_req.write) === 1'b1) begin
            busy_run <= busy_run + 1;
        end else if (busy_run != 0) begin
            last_busy <= busy_run;
            busy_run <= 0;
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Bus write; entered just after a rising edge, returns just after one
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic ah, wh, ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(negedge aclk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            @(posedge aclk);
            if (ah) begin
                awvalid <= 1'b0;
                ad = 1'b1;
            end
            if (wh) begin
                wvalid <= 1'b0;
                wd = 1'b1;
            end
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        wb = bresp;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ah;
        ah = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!ah) begin
            @(negedge aclk);
            ah = arready;
            @(posedge aclk);
        end
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge aclk);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        rd(`NV_OFF_CTL, rv, rr);
        while (rv[1] !== 1'b0 && n < 300) begin
            rd(`NV_OFF_CTL, rv, rr);
            n++;
        end
        chk("prog_strobe_clear", 32'h0, {31'h0, rv[1]});
    endtask

    task automatic rd_byte(input logic [11:0] a, input logic [7:0] exp);
        wr(`NV_OFF_ADDR, {20'h0, a});
        wr(`NV_OFF_CTL, 32'h1);
        rd(`NV_OFF_DATA, rv, rr);
        chk("read_byte", {24'h0, exp}, rv);
        repeat (3) @(posedge aclk);
        chk("read_stall", 32'h4, last_stall);
    endtask

    task automatic prog(input logic [11:0] a, input logic [7:0] d, input logic [1:0] m);
        wr(`NV_OFF_ADDR, {20'h0, a});
        wr(`NV_OFF_DATA, {24'h0, d});
        gie <= 1'b0;
        wr(`NV_OFF_CTL, {26'h0, m, 4'hC});
        wr(`NV_OFF_CTL, {26'h0, m, 4'hA});
        gie <= 1'b1;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        #(100 * 8000);
        mismatches++;
        $display("[FAIL] watchdog expected done seen hang");
        final_report();
    end

    initial begin
        aresetn = 1'b0;
        por_resetn = 1'b0;
        aclk_en = 1'b1;
        gie = 1'b1;
        flash_busy = 1'b0;
        awaddr = 4'h0;
        araddr = 4'h0;
        wdata = 32'h0;
        wstrb = 4'hF;
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        bready = 1'b1;
        rready = 1'b1;
        modes = '{2'b01, 2'b10, 2'b11};
        exps = '{8'hFF, 8'hA5, 8'hA5};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        por_resetn <= 1'b1;
        @(posedge aclk);
        rd(`NV_OFF_CTL, rv, rr);
        chk("ctl_reset", 32'h0, rv);
        wr(`NV_OFF_ADDR, 32'h0000F123);
        rd(`NV_OFF_ADDR, rv, rr);
        chk("addr_width", 32'h123, rv);
        rd(4'h2, rv, rr);
        chk("unmapped_resp", {30'h0, `NV_RESP_SLVERR}, {30'h0, rr});
        wr(4'h2, 32'h0);
        chk("unmapped_wresp", {30'h0, `NV_RESP_SLVERR}, {30'h0, wb});
        rd_byte(12'h123, 8'h79);
        $display("[DONE] reset, map and read");
        wr(`NV_OFF_CTL, 32'h4);
        rd(`NV_OFF_CTL, rv, rr);
        chk("mpe_set", 32'h4, rv);
        repeat (6) @(posedge aclk);
        rd(`NV_OFF_CTL, rv, rr);
        chk("mpe_expired", 32'h0, rv);
        wr(`NV_OFF_CTL, 32'h2);
        rd(`NV_OFF_CTL, rv, rr);
        chk("late_strobe", 32'h0, rv);
        // Low clock enable must hold the expiry count
        wr(`NV_OFF_CTL, 32'h4);
        aclk_en <= 1'b0;
        repeat (10) @(posedge aclk);
        aclk_en <= 1'b1;
        rd(`NV_OFF_CTL, rv, rr);
        chk("enable_freeze", 32'h4, rv);
        repeat (6) @(posedge aclk);
        $display("[DONE] master enable window");
        prog(12'h123, 8'h3C, 2'b00);
        repeat (3) @(posedge aclk);
        chk("prog_stall", 32'h2, last_stall);
        rd(`NV_OFF_CTL, rv, rr);
        chk("busy_ctl", 32'h0A, rv);
        chk("irq_busy", 32'h0, {31'h0, ready_irq});
        wr(`NV_OFF_ADDR, 32'h456);
        wr(`NV_OFF_CTL, 32'h29);
        rd(`NV_OFF_CTL, rv, rr);
        chk("busy_hold", 32'h0A, rv);
        rd(`NV_OFF_ADDR, rv, rr);
        chk("addr_locked", 32'h123, rv);
        rd(`NV_OFF_DATA, rv, rr);
        chk("read_refused", 32'h3C, rv);
        wait_idle();
        chk("irq_ready", 32'h1, {31'h0, ready_irq});
        // 20 ticks of a 340 ns oscillator, about 68 aclk cycles
        chk("prog_time", 32'h1, {31'h0, (last_busy > 61 && last_busy < 75)});
        rd_byte(12'h123, 8'h3C);
        $display("[DONE] atomic program");
        for (int i = 0; i < 3; i++) begin
            prog(12'h200, (modes[i] == 2'b11) ? 8'h00 : 8'hA5, modes[i]);
            wait_idle();
            rd_byte(12'h200, exps[i]);
        end
        $display("[DONE] mode table");
        flash_busy <= 1'b1;
        prog(12'h200, 8'h00, 2'b00);
        rd(`NV_OFF_CTL, rv, rr);
        chk("flash_block", 32'h0, {31'h0, rv[1]});
        flash_busy <= 1'b0;
        $display("[DONE] flash interlock");
        prog(12'h300, 8'h66, 2'b10);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`NV_OFF_CTL, rv, rr);
        chk("reset_busy", 32'h22, rv);
        wait_idle();
        // 10 ticks of a 340 ns oscillator, about 34 aclk cycles
        chk("split_time", 32'h1, {31'h0, (last_busy > 28 && last_busy < 41)});
        rd_byte(12'h300, 8'h42);
        wr(`NV_OFF_CTL, 32'h38);
        rd(`NV_OFF_CTL, rv, rr);
        chk("mode_set", 32'h38, rv);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`NV_OFF_CTL, rv, rr);
        chk("reset_idle", 32'h0, rv);
        $display("[DONE] reset during program");
        final_report();
    end
endmodule // tb_top
